// *** verilog/sync_serial_16bit_port.sv ***
// synchronous 16-bit serial port with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "ssio_cfg.svh"

module sync_serial_16bit_port #(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_data_pin,
  output logic tx_data_pin_oe,
  input wire logic tx_clock_pin_level,
  output logic tx_clock_pin_drive,
  output logic tx_clock_pin_oe,
  input wire logic rx_data_pin,
  input wire logic rx_clock_pin_level,
  output logic rx_clock_pin_drive,
  output logic rx_clock_pin_oe,
  output logic tx_refill_req,
  output logic rx_read_req
);
  import ssio_pkg::*;

  port_state_t q;
  port_state_t d;

  logic gen_clk;
  logic gen_rise;
  logic gen_fall;
  logic [6:0] gen_count;
  logic acc_wr;
  logic acc_rd;
  logic wr_txw;
  logic wr_ctl;
  logic wr_ms;
  logic wr_baud;
  logic wr_pre;
  logic wr_pin;
  logic wr_cfg;
  logic rd_rxw;
  logic [31:0] rdata;
  logic mapped;
  logic tx_fall;
  logic rx_rise;
  logic tx_start;
  logic tx_done;
  logic rx_go;
  logic rx_done;
  logic [15:0] tx_next;
  logic [15:0] rx_word;
  logic tx_active;

  // word-aligned byte address of a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  baud_rate_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .use_half_rate(q.clk_cfg[`CFG_SRC_HALF]),
    .prescale(q.prescale),
    .baud_gen_enable(q.baud_ctl[`BAUD_EN_BIT]),
    .reload_value(q.baud_ctl[6:0]),
    .gen_clk(gen_clk),
    .gen_rise(gen_rise),
    .gen_fall(gen_fall),
    .count(gen_count)
  );

  // bus access decode
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign wr_txw = acc_wr & hit(paddr, `IDX_TX_WORD);
  assign wr_ctl = acc_wr & hit(paddr, `IDX_CTL_STAT);
  assign wr_ms = acc_wr & hit(paddr, `IDX_MS_SEL);
  assign wr_baud = acc_wr & hit(paddr, `IDX_BAUD_CTL);
  assign wr_pre = acc_wr & hit(paddr, `IDX_PRESCALE);
  assign wr_pin = acc_wr & hit(paddr, `IDX_PIN_SEL);
  assign wr_cfg = acc_wr & hit(paddr, `IDX_CLK_CFG);
  assign rd_rxw = acc_rd & hit(paddr, `IDX_RX_WORD);

  // read data mux, captured in the setup cycle
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    if (hit(paddr, `IDX_RX_WORD)) begin
      rdata = {16'h0000, q.rx_buf};
    end else if (hit(paddr, `IDX_CTL_STAT)) begin
      rdata = {24'h00_0000, q.tx_underflow_flag, q.tx_holding_empty, q.tx_req_enable,
               q.tx_enable, q.rx_overflow_flag, q.rx_holding_full, q.rx_req_enable,
               q.rx_enable};
    end else if (hit(paddr, `IDX_MS_SEL)) begin
      rdata = {30'h0000_0000, q.tx_master, q.rx_master};
    end else if (hit(paddr, `IDX_COUNTDOWN)) begin
      rdata = {24'h00_0000, q.baud_ctl[`BAUD_EN_BIT], gen_count};
    end else if (hit(paddr, `IDX_PIN_SEL)) begin
      rdata = {24'h00_0000, q.pin_sel};
    end else if (hit(paddr, `IDX_CLK_CFG)) begin
      rdata = {24'h00_0000, q.clk_cfg};
    end else if (!(hit(paddr, `IDX_TX_WORD) || hit(paddr, `IDX_BAUD_CTL) ||
                   hit(paddr, `IDX_PRESCALE))) begin
      mapped = 1'b0;
    end
  end

  // serial clock edges: generator in master mode, pin in slave mode
  assign tx_fall = q.tx_master ? gen_fall : (q.txc_prev & ~tx_clock_pin_level);
  assign rx_rise = q.rx_master ? gen_rise : (~q.rxc_prev & rx_clock_pin_level);

  assign tx_next = wr_txw ? pwdata[15:0] : q.tx_buf;
  assign tx_start = (q.tx_st == TX_IDLE) & q.tx_enable;
  assign tx_done = (q.tx_st == TX_SHIFT) & tx_fall & (q.tx_cnt == `WORD_LAST);
  assign rx_go = q.rx_act | q.rx_enable;
  assign rx_done = rx_go & rx_rise & (q.rx_cnt == `WORD_LAST);
  assign rx_word = {q.rx_sh[14:0], rx_data_pin};
  assign tx_active = q.tx_st != TX_IDLE;

  always_comb begin
    d = q;
    d.txc_prev = tx_clock_pin_level;
    d.rxc_prev = rx_clock_pin_level;
    if (psel & ~penable) begin
      d.prdata = rdata;
      d.slverr = ~mapped;
    end
    // software writes first, so hardware sets below win
    if (wr_txw) begin
      d.tx_buf = pwdata[15:0];
      d.tx_holding_empty = 1'b0;
    end
    if (wr_ctl) begin
      d.tx_underflow_flag = q.tx_underflow_flag & pwdata[`CS_TX_UNDER];
      d.rx_overflow_flag = q.rx_overflow_flag & pwdata[`CS_RX_OVER];
      d.tx_req_enable = pwdata[`CS_TX_REQ_EN];
      d.tx_enable = pwdata[`CS_TX_EN];
      d.rx_req_enable = pwdata[`CS_RX_REQ_EN];
      d.rx_enable = pwdata[`CS_RX_EN];
    end
    if (wr_ms) begin
      d.tx_master = pwdata[`MS_TX_MASTER];
      d.rx_master = pwdata[`MS_RX_MASTER];
    end
    if (wr_baud) begin
      d.baud_ctl = pwdata[7:0];
    end
    if (wr_pre) begin
      d.prescale = pwdata[8:0];
    end
    if (wr_pin) begin
      d.pin_sel = pwdata[7:0];
    end
    if (wr_cfg) begin
      d.clk_cfg = pwdata[7:0];
    end
    if (rd_rxw) begin
      d.rx_holding_full = 1'b0;
    end
    // transmitter
    case (q.tx_st)
      TX_IDLE: begin
        if (q.tx_enable) begin
          d.tx_sh = tx_next;
          d.tx_holding_empty = 1'b1;
          d.tx_cnt = 4'h0;
          d.tx_st = TX_PRIME;
        end
      end
      TX_PRIME: begin
        if (tx_fall) begin
          d.tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tx_fall) begin
          if (q.tx_cnt != `WORD_LAST) begin
            d.tx_sh = {q.tx_sh[14:0], 1'b0};
            d.tx_cnt = q.tx_cnt + 4'h1;
          end else if (q.tx_enable) begin
            d.tx_sh = tx_next;
            d.tx_cnt = 4'h0;
            d.tx_holding_empty = 1'b1;
            if (q.tx_holding_empty & ~wr_txw) begin
              d.tx_underflow_flag = 1'b1;
            end
          end else begin
            d.tx_st = TX_IDLE;
          end
        end
      end
      default: begin
        d.tx_st = TX_IDLE;
      end
    endcase
    // receiver
    if (rx_go & rx_rise) begin
      d.rx_sh = rx_word;
      d.rx_cnt = q.rx_cnt + 4'h1;
      d.rx_act = 1'b1;
      if (q.rx_cnt == `WORD_LAST) begin
        d.rx_buf = rx_word;
        d.rx_holding_full = 1'b1;
        d.rx_act = q.rx_enable;
        if (q.rx_holding_full & ~rd_rxw) begin
          d.rx_overflow_flag = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.tx_st <= TX_IDLE;
      q.tx_underflow_flag <= `TX_UNDER_RESET;
      q.tx_holding_empty <= `TX_EMPTY_RESET;
      q.txc_prev <= `PIN_IDLE_LEVEL;
      q.rxc_prev <= `PIN_IDLE_LEVEL;
    end else begin
      q <= d;
    end
  end

  // bus answers in the first access cycle
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.slverr;

  // pins float whenever the channel is stopped
  assign tx_data_pin = q.tx_sh[15];
  assign tx_data_pin_oe = tx_active & q.pin_sel[`PIN_TX_DATA];
  assign tx_clock_pin_drive = gen_clk;
  assign tx_clock_pin_oe = tx_active & q.tx_master;
  assign rx_clock_pin_drive = gen_clk;
  assign rx_clock_pin_oe = rx_go & q.rx_master & q.pin_sel[`PIN_RX_CLK];
  assign tx_refill_req = q.tx_holding_empty & q.tx_req_enable;
  assign rx_read_req = q.rx_holding_full & q.rx_req_enable;

  tx_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_start |=> q.tx_holding_empty && tx_data_pin == $past(tx_next[15]))
    else $error("enable did not load the shift register");
  buf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_txw && !tx_start && !tx_done |=> !q.tx_holding_empty)
    else $error("buffer write did not clear empty flag");
  tx_underflow_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && q.tx_enable && q.tx_holding_empty && !wr_txw |=>
      q.tx_underflow_flag && q.tx_sh == $past(q.tx_buf))
    else $error("underflow not flagged or old word not resent");
  tx_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && !q.tx_enable |=> !tx_data_pin_oe && !tx_clock_pin_oe)
    else $error("pins still driven after disabled word ended");
  hold_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.tx_st == TX_PRIME && tx_fall |=> tx_data_pin == $past(q.tx_sh[15]))
    else $error("top bit left the pin before second falling edge");
  rx_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done |=> q.rx_holding_full && q.rx_buf == $past(rx_word))
    else $error("received word not stored");
  rx_overflow_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done && q.rx_holding_full && !rd_rxw |=> q.rx_overflow_flag)
    else $error("overflow not flagged");
  rx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_rxw && !rx_done |=> !q.rx_holding_full)
    else $error("buffer read did not clear full flag");
  err_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && pwdata[`CS_TX_UNDER] && !tx_done |=> q.tx_underflow_flag == $past(q.tx_underflow_flag))
    else $error("writing one changed the underflow flag");
  ovf_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && pwdata[`CS_RX_OVER] && !rx_done |=> q.rx_overflow_flag == $past(q.rx_overflow_flag))
    else $error("writing one changed the overflow flag");
  under_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && !pwdata[`CS_TX_UNDER] && !tx_done |=> !q.tx_underflow_flag)
    else $error("writing zero did not clear the underflow flag");
  ovf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && !pwdata[`CS_RX_OVER] && !rx_done |=> !q.rx_overflow_flag)
    else $error("writing zero did not clear the overflow flag");

  // transmit path
  refill_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_start && q.tx_req_enable && !wr_ctl |=> tx_refill_req)
    else $error("refill request missing after load");
  tx_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_txw && tx_start |=> q.tx_sh == $past(pwdata[15:0]))
    else $error("word written during load not loaded");
  tx_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.tx_st == TX_SHIFT && tx_fall && q.tx_cnt != `WORD_LAST |=> tx_data_pin == $past(q.tx_sh[14]))
    else $error("next lower bit not shifted out");
  tx_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_active && !tx_fall |=> $stable(tx_data_pin))
    else $error("data changed without a falling clock edge");
  tx_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && q.tx_enable |=> q.tx_st == TX_SHIFT && q.tx_holding_empty)
    else $error("enabled transmitter did not reload");
  tx_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_done && !q.tx_enable && !wr_txw |=>
      q.tx_st == TX_IDLE && q.tx_holding_empty == $past(q.tx_holding_empty))
    else $error("disabled transmitter loaded the buffer");

  // receive path
  read_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done && q.rx_req_enable && !wr_ctl |=> rx_read_req)
    else $error("read request missing after word stored");
  rx_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_go && rx_rise |=> q.rx_sh == $past(rx_word))
    else $error("receive shift register did not take the bit");
  rx_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_enable && !q.rx_act && rx_rise |=> q.rx_act && q.rx_sh[0] == $past(rx_data_pin))
    else $error("first rising edge after enable not sampled");
  rx_still_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_go |=> $stable(q.rx_sh) && $stable(q.rx_cnt))
    else $error("stopped receiver still shifting");
  rx_finish_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_done && !q.rx_enable && !wr_ctl |=> !rx_go)
    else $error("disabled receiver did not stop after its word");
  rx_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_go |-> !rx_clock_pin_oe)
    else $error("receive clock driven while receiver stopped");
endmodule // sync_serial_16bit_port

`default_nettype wire

// *** verilog/ssio_cfg.svh ***
// register indices, field positions, reset values and divider counts
`ifndef SSIO_CFG_SVH
`define SSIO_CFG_SVH
`define IDX_TX_WORD 16'hF480
`define IDX_RX_WORD 16'hF482
`define IDX_BAUD_CTL 16'hF484
`define IDX_CTL_STAT 16'hF486
`define IDX_MS_SEL 16'hF488
`define IDX_COUNTDOWN 16'hF48A
`define IDX_PRESCALE 16'hF804
`define IDX_PIN_SEL 16'hF826
`define IDX_CLK_CFG 16'hF836
`define CS_TX_UNDER 7
`define CS_TX_EMPTY 6
`define CS_TX_REQ_EN 5
`define CS_TX_EN 4
`define CS_RX_OVER 3
`define CS_RX_FULL 2
`define CS_RX_REQ_EN 1
`define CS_RX_EN 0
`define MS_TX_MASTER 1
`define MS_RX_MASTER 0
`define PIN_TX_DATA 0
`define PIN_RX_CLK 1
`define CFG_SRC_HALF 2
`define BAUD_EN_BIT 7
`define TX_UNDER_RESET 1'b1
`define TX_EMPTY_RESET 1'b1
`define PIN_IDLE_LEVEL 1'b1
`define HALF_RATE_LAST 2'h3
`define PRESCALE_EXTRA 11'h003
`define WORD_LAST 4'hF
`endif

// *** verilog/ssio_pkg.sv ***
// types shared by the serial port and its baud-rate generator
package ssio_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_PRIME, TX_SHIFT} tx_state_t;

  typedef struct packed {
    logic [1:0] half_cnt;
    logic [10:0] pre_cnt;
    logic [6:0] cnt;
    logic out;
  } gen_state_t;

  typedef struct packed {
    tx_state_t tx_st;
    logic [15:0] tx_buf;
    logic [15:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_holding_empty;
    logic tx_underflow_flag;
    logic tx_req_enable;
    logic tx_enable;
    logic [15:0] rx_buf;
    logic [15:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_act;
    logic rx_holding_full;
    logic rx_overflow_flag;
    logic rx_req_enable;
    logic rx_enable;
    logic tx_master;
    logic rx_master;
    logic [7:0] pin_sel;
    logic [7:0] clk_cfg;
    logic [7:0] baud_ctl;
    logic [8:0] prescale;
    logic txc_prev;
    logic rxc_prev;
    logic [31:0] prdata;
    logic slverr;
  } port_state_t;
endpackage

// *** verilog/baud_rate_gen.sv ***
// baud-rate generator: source select, prescaler and seven-bit down counter
`timescale 1ns/100ps
`default_nettype none
`include "ssio_cfg.svh"

module baud_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic use_half_rate,
  input wire logic [8:0] prescale,
  input wire logic baud_gen_enable,
  input wire logic [6:0] reload_value,
  output logic gen_clk,
  output logic gen_rise,
  output logic gen_fall,
  output logic [6:0] count
);
  import ssio_pkg::*;

  gen_state_t q;
  gen_state_t d;
  logic [10:0] pre_last;
  logic tick;
  logic toggle;

  // prescaled clock ticks once every 2*(prescale+2) pclk cycles
  assign pre_last = {1'b0, prescale, 1'b0} + `PRESCALE_EXTRA;
  assign tick = use_half_rate ? (q.half_cnt == `HALF_RATE_LAST) : (q.pre_cnt >= pre_last);
  assign toggle = baud_gen_enable & tick & (q.cnt == 7'h00);

  always_comb begin
    d = q;
    d.half_cnt = q.half_cnt + 2'h1;
    d.pre_cnt = (q.pre_cnt >= pre_last) ? 11'h000 : q.pre_cnt + 11'h001;
    if (!baud_gen_enable) begin
      d.cnt = 7'h00;
      d.out = 1'b0;
    end else if (tick) begin
      if (q.cnt == 7'h00) begin
        d.cnt = reload_value;
        d.out = ~q.out;
      end else begin
        d.cnt = q.cnt - 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gen_clk = q.out;
  assign gen_rise = toggle & ~q.out;
  assign gen_fall = toggle & q.out;
  assign count = q.cnt;

  gen_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !baud_gen_enable |=> count == 7'h00 && !gen_clk)
    else $error("generator not cleared when disabled");
  gen_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    toggle |=> count == $past(reload_value) && gen_clk != $past(gen_clk))
    else $error("generator did not reload and toggle");
  gen_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    baud_gen_enable && tick && count != 7'h00 && $stable(baud_gen_enable) |=>
      count == $past(count) - 7'h01)
    else $error("generator count did not step down");
endmodule // baud_rate_gen

`default_nettype wire

// *** sim/serial_far_end.sv ***
// far-side serial device: captures transmitted words, clocks words into the receiver
`timescale 1ns/100ps
`default_nettype none

module serial_far_end (
  input wire logic pclk,
  input wire logic tx_data_pin,
  input wire logic tx_data_pin_oe,
  input wire logic tx_clock_pin_drive,
  input wire logic tx_clock_pin_oe,
  output logic tx_clock_pin_level,
  input wire logic rx_clock_pin_drive,
  input wire logic rx_clock_pin_oe,
  output logic rx_clock_pin_level,
  output logic rx_data_pin
);
  logic [15:0] got_q[$];
  logic [15:0] sh;
  logic armed, prev, poe, tclk, tdat, rclk;
  int nbits;
  // released transmit lines float high through pull-ups; a released receive clock follows the far end's rclk
  assign tclk = tx_clock_pin_oe ? tx_clock_pin_drive : 1'b1;
  assign tdat = tx_data_pin_oe ? tx_data_pin : 1'b1;
  assign tx_clock_pin_level = tclk;
  assign rx_clock_pin_level = rx_clock_pin_oe ? rx_clock_pin_drive : rclk;
  initial begin
    rclk = 1'b1;
    rx_data_pin = 1'b1;
    armed = 1'b0;
    prev = 1'b1;
    poe = 1'b0;
    nbits = 0;
    sh = '0;
  end
  // sample on rising clock edges after the first falling edge, msb first
  // looked at mid-cycle, and only edges seen while the clock was driven both times
  always @(negedge pclk) begin
    prev <= tclk;
    poe <= tx_clock_pin_oe;
    if (!tx_clock_pin_oe) begin
      armed <= 1'b0;
      nbits <= 0;
    end else if (poe && prev && !tclk) begin
      armed <= 1'b1;
    end else if (poe && !prev && tclk && armed && tx_data_pin_oe) begin
      sh <= {sh[14:0], tdat};
      nbits <= (nbits == 15) ? 0 : nbits + 1;
      if (nbits == 15) begin
        got_q.push_back({sh[14:0], tdat});
      end
    end
  end
  // slave clock of eight pclk cycles, data changed on the falling edge
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      rclk <= 1'b0;
      rx_data_pin <= w[i];
      repeat (4) @(posedge pclk);
      rclk <= 1'b1;
      repeat (3) @(posedge pclk);
    end
    rx_data_pin <= 1'b1;
  endtask
endmodule // serial_far_end
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none
`include "ssio_cfg.svh"

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic tx_data_pin, tx_data_pin_oe, tx_clock_pin_level, tx_clock_pin_drive, tx_clock_pin_oe;
  logic rx_data_pin, rx_clock_pin_level, rx_clock_pin_drive, rx_clock_pin_oe;
  logic tx_refill_req, rx_read_req;
  int err_total, compares, cyc, n;
  real t0;
  int g_half[5] = '{1, 0, 0, 0, 1};
  int g_pre[5] = '{0, 1, 2, 511, 0};
  int g_bv[5] = '{3, 1, 0, 0, 63};
  int g_per[5] = '{32, 24, 16, 2052, 512};
  logic [15:0] r_idx[5] = '{`IDX_CTL_STAT, `IDX_MS_SEL, `IDX_COUNTDOWN, `IDX_PIN_SEL, `IDX_CLK_CFG};
  logic [31:0] r_val[5] = '{32'hC0, 32'h00, 32'h00, 32'h00, 32'h00};

  sync_serial_16bit_port i_sync_serial_16bit_port (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data_pin(tx_data_pin),
    .tx_data_pin_oe(tx_data_pin_oe), .tx_clock_pin_level(tx_clock_pin_level),
    .tx_clock_pin_drive(tx_clock_pin_drive), .tx_clock_pin_oe(tx_clock_pin_oe),
    .rx_data_pin(rx_data_pin), .rx_clock_pin_level(rx_clock_pin_level),
    .rx_clock_pin_drive(rx_clock_pin_drive), .rx_clock_pin_oe(rx_clock_pin_oe),
    .tx_refill_req(tx_refill_req), .rx_read_req(rx_read_req));
  serial_far_end i_serial_far_end (.pclk(pclk), .tx_data_pin(tx_data_pin),
    .tx_data_pin_oe(tx_data_pin_oe), .tx_clock_pin_drive(tx_clock_pin_drive),
    .tx_clock_pin_oe(tx_clock_pin_oe), .tx_clock_pin_level(tx_clock_pin_level),
    .rx_clock_pin_drive(rx_clock_pin_drive), .rx_clock_pin_oe(rx_clock_pin_oe),
    .rx_clock_pin_level(rx_clock_pin_level), .rx_data_pin(rx_data_pin));

  task automatic conclude();
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [31:0] wd,
      output logic [31:0] rdat, output logic rerr);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next request never re-raises psel in the same step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, idx, wd, x, y);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] rdat);
    logic y;
    apb(1'b0, idx, 32'h0, rdat, y);
  endtask
  task automatic wait_lv(input int sel, input logic v);
    n = 0;
    while ((sel == 0 ? tx_refill_req : sel == 1 ? tx_data_pin_oe : rx_clock_pin_oe) !== v &&
           n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) err_total++;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, tx_data_pin_oe, tx_clock_pin_oe, rx_clock_pin_oe}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(r_idx[i], d);
      chk(d, r_val[i]);
    end
    apb(1'b0, 16'hF48C, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    wr(`IDX_CTL_STAT, 32'h80);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'hC0);
    wr(`IDX_CTL_STAT, 32'h00);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'h40);
    // generator source, prescale and reload combinations, top prescale 511 and zero reload included
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_CLK_CFG, 32'(g_half[i]) << `CFG_SRC_HALF);
      wr(`IDX_PRESCALE, 32'(g_pre[i]));
      wr(`IDX_BAUD_CTL, 32'h80 | 32'(g_bv[i]));
      @(posedge tx_clock_pin_drive);
      @(posedge tx_clock_pin_drive);
      t0 = $realtime;
      @(posedge tx_clock_pin_drive);
      chk(32'($rtoi(($realtime - t0) / 25.0)), 32'(g_per[i]));
      @(posedge pclk);
      rd(`IDX_COUNTDOWN, d);
      chk(d & 32'h80, 32'h80);
    end
    wr(`IDX_BAUD_CTL, 32'h00);
    rd(`IDX_COUNTDOWN, d);
    chk(d, 32'h00);
    // master transmit: two words written, third resent after underflow
    wr(`IDX_CLK_CFG, 32'h04);
    wr(`IDX_BAUD_CTL, 32'h81);
    wr(`IDX_PIN_SEL, 32'h03);
    wr(`IDX_MS_SEL, 32'h02);
    wr(`IDX_TX_WORD, 32'hA5C3);
    rd(`IDX_CTL_STAT, d);
    chk({d[31:1], tx_refill_req}, 32'h0);
    wr(`IDX_CTL_STAT, 32'h30);
    wait_lv(0, 1'b1);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'h70);
    wr(`IDX_TX_WORD, 32'h1234);
    @(posedge pclk);
    chk({31'h0, tx_refill_req}, 32'h0);
    n = 0;
    while (i_serial_far_end.got_q.size() < 2 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) err_total++;
    repeat (8) @(posedge pclk);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'hF0);
    wr(`IDX_CTL_STAT, 32'h80);
    wait_lv(1, 1'b0);
    chk(32'(i_serial_far_end.got_q.size()), 32'd3);
    chk({i_serial_far_end.got_q[0], i_serial_far_end.got_q[1]}, 32'hA5C31234);
    chk({16'h0, i_serial_far_end.got_q[2]}, 32'h1234);
    chk({31'h0, tx_clock_pin_oe}, 32'h0);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'hC0);
    // slave receive: second word lands unread and overwrites the first
    wr(`IDX_CTL_STAT, 32'h03);
    i_serial_far_end.send(16'hBEEF);
    repeat (4) @(posedge pclk);
    rd(`IDX_CTL_STAT, d);
    chk({d[31:1], rx_read_req}, 32'h47);
    i_serial_far_end.send(16'h5A5A);
    repeat (4) @(posedge pclk);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'h4F);
    rd(`IDX_RX_WORD, d);
    chk(d, 32'h5A5A);
    rd(`IDX_CTL_STAT, d);
    chk({d[31:1], rx_read_req}, 32'h4A);
    // slave receive of one word: disabled mid-word, the word still lands
    fork
      i_serial_far_end.send(16'hC3A5);
      begin
        repeat (40) @(posedge pclk);
        wr(`IDX_CTL_STAT, 32'h02);
      end
    join
    repeat (4) @(posedge pclk);
    i_serial_far_end.send(16'h0F0F);
    repeat (4) @(posedge pclk);
    rd(`IDX_CTL_STAT, d);
    chk(d, 32'h46);
    rd(`IDX_RX_WORD, d);
    chk(d, 32'hC3A5);
    // master receive: generator drives the clock pin, idle-high data gives all ones
    wr(`IDX_MS_SEL, 32'h03);
    wr(`IDX_CTL_STAT, 32'h01);
    repeat (20) @(posedge pclk);
    chk({31'h0, rx_clock_pin_oe}, 32'h1);
    wr(`IDX_CTL_STAT, 32'h00);
    wait_lv(2, 1'b0);
    rd(`IDX_RX_WORD, d);
    chk(d, 32'hFFFF);
    conclude();
  end
endmodule // testbench
`default_nettype wire
